// ===== shared/tws_pkg.sv
// Shared constants and types of the two-wire serial memory slave
`default_nettype none
package tws_pkg;
   // ==========================================================================
   // Array geometry
   localparam int unsigned BYTE_W      = 8;
   localparam int unsigned ADDR_W      = 13;
   localparam int unsigned OFS_W       = 5;
   localparam int unsigned PAGE_BYTES  = 32;
   localparam int unsigned MEM_BYTES   = 8192;
   localparam int unsigned HI_BITS     = 5;
   localparam int unsigned SEL_W       = 3;
   localparam int unsigned CNT_W       = 4;
   // Upper quadrant, selected by the two top address bits
   localparam logic [1:0]  PROT_QUAD   = 2'h3;
   // Bit counter value when the eighth data bit of a byte arrives
   localparam logic [3:0]  BIT_LAST    = 4'h7;
   localparam logic [3:0]  BIT_ACK     = 4'h8;
   // Device type code: arbitrary neutral value
   localparam logic [3:0]  DEV_TYPE_DEF = 4'h5;
   // ==========================================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned T_WC_NS       = 5000000;
   localparam int unsigned WC_CYCLES     = T_WC_NS / CLK_PERIOD_NS;
   localparam int unsigned WC_CNT_W      = 20;
   // ==========================================================================
   // Protocol states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DEV,
      ST_AHI,
      ST_ALO,
      ST_WDAT,
      ST_RDAT,
      ST_WAIT
   } tws_state_t;
endpackage : tws_pkg
`default_nettype wire

// ===== design/tws_link_shift.sv
// Bit shifter clocked by the serial clock of the link
`default_nettype none
module tws_link_shift #(
   parameter int unsigned W = tws_pkg::BYTE_W
) (
   input  wire logic         scl,
   input  wire logic         sda_in,
   output logic [W-1:0]      rx_byte,
   output logic              bit_tgl
);
   import tws_pkg::*;

   // The serial clock stops outside frames, so there is no reset edge to use;
   // the toggle only matters relative to its own last value.
   logic [W-1:0] shift_ff = '0;
   logic         tgl_ff   = 1'b0;
   logic [W-1:0] nxt_shift;
   logic         nxt_tgl;

   // ==========================================================================
   // Sample data on each rising serial clock
   always_comb begin
      nxt_shift = {shift_ff[W-2:0], sda_in};
      nxt_tgl   = ~tgl_ff;
   end

   always_ff @(posedge scl) begin
      shift_ff <= nxt_shift;
      tgl_ff   <= nxt_tgl;
   end

   // Held stable until the next rising edge, far longer than the crossing
   assign rx_byte = shift_ff;
   assign bit_tgl = tgl_ff;
endmodule : tws_link_shift
`default_nettype wire

// ===== design/tws_eeprom_slave.sv
// Two-wire serial memory slave: protocol engine, page buffer and array
`default_nettype none
// Notes on behaviour
// R1: Data changes only while serial clock low
// R2: Ignore everything until a start is seen
// R3: Stop ends any transfer, back to standby
// R4: Release after eight bits, receiver acks ninth
// R5: Ack address match and each written byte
// R6: Read: continue on ack, stop on none
// R7: Master stops after read without ack
// R8: Type code and select straps must match
// R9: Last address bit chooses read or write
// R10: Mismatch: no ack, return to standby
// R11: Array is 256 pages of 32 bytes
// R12: Low byte bits 4..0 are in-page offset
// R13: Byte write acks address bytes and data
// R14: Stop after write data starts write cycle
// R15: Busy writing: inputs ignored, line released
// R16: Page load takes up to 32 bytes
// R17: Only in-page offset increments per byte
// R18: Master points page write at page start
// R19: Protect high blocks upper quadrant writes
// R20: Master drives clock, device always slave
// R21: Master stops only after line released
// R22: No address ack while write in progress
// R23: Offset wraps to first byte of page
// R24: Address is 13 bits, upper bits ignored
module tws_eeprom_slave #(
   parameter int unsigned WC_CYC   = tws_pkg::WC_CYCLES,
   parameter logic [3:0]  DEV_TYPE = tws_pkg::DEV_TYPE_DEF
) (
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   input  wire logic                      scl,
   input  wire logic                      sda_in,
   output logic                           sda_out,
   output logic                           sda_oe,
   input  wire logic [tws_pkg::SEL_W-1:0] chip_select_straps,
   input  wire logic                      write_protect,
   output logic                           write_busy
);
   import tws_pkg::*;

   // ==========================================================================
   // Helpers
   function automatic logic [ADDR_W-1:0] page_step(input logic [ADDR_W-1:0] a);
      page_step = {a[ADDR_W-1:OFS_W], a[OFS_W-1:0] + 5'h01};
   endfunction : page_step

   // ==========================================================================
   // Link-side shifter
   logic [BYTE_W-1:0] link_byte;
   logic              link_tgl;

   tws_link_shift #(.W(BYTE_W)) u_link (
      .scl     (scl),
      .sda_in  (sda_in),
      .rx_byte (link_byte),
      .bit_tgl (link_tgl)
   );

   // ==========================================================================
   // Pin synchronisers: straps, protect, clock, data and bit toggle
   localparam int unsigned SYN_W = SEL_W + 4;
   localparam logic [SYN_W-1:0] SYN_IDLE = 7'h03; // Bus idles with clock and data high
   logic [SYN_W-1:0] meta_ff;
   logic [SYN_W-1:0] sync_ff;
   logic [2:0]       prev_ff;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_ff <= SYN_IDLE;
         sync_ff <= SYN_IDLE;
         prev_ff <= SYN_IDLE[2:0];
      end else begin
         meta_ff <= {chip_select_straps, write_protect, link_tgl, sda_in, scl};
         sync_ff <= meta_ff;
         prev_ff <= sync_ff[2:0];
      end
   end

   logic scl_s;
   logic sda_s;
   logic start_det;
   logic stop_det;
   logic scl_fall;
   logic bit_evt;
   logic wp_s;
   logic [SEL_W-1:0] sel_s;

   // Start and stop are data edges while the clock stays high
   assign scl_s     = sync_ff[0];
   assign sda_s     = sync_ff[1];
   assign wp_s      = sync_ff[3];
   assign sel_s     = sync_ff[SYN_W-1:4];
   assign start_det = scl_s & prev_ff[0] & prev_ff[1] & ~sda_s;   // R1
   assign stop_det  = scl_s & prev_ff[0] & ~prev_ff[1] & sda_s;   // R1
   assign scl_fall  = prev_ff[0] & ~scl_s;
   assign bit_evt   = sync_ff[2] ^ prev_ff[2];

   // ==========================================================================
   // Protocol state
   tws_state_t            state_ff, nxt_state;
   logic [CNT_W-1:0]      cnt_ff, nxt_cnt;
   logic [ADDR_W-1:0]     addr_ff, nxt_addr;
   logic [BYTE_W-1:0]     tx_ff, nxt_tx;
   logic                  oe_ff, nxt_oe;
   logic                  ack_ff, nxt_ack;
   logic                  busy_ff, nxt_busy;
   logic [WC_CNT_W-1:0]   wc_ff, nxt_wc;
   logic [BYTE_W-1:0]     pbuf_ff [PAGE_BYTES];
   logic [BYTE_W-1:0]     nxt_pbuf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pval_ff, nxt_pval;
   logic [BYTE_W-1:0]     mem [MEM_BYTES];
   logic                  mem_we;
   logic                  byte_done;
   logic                  ack_rise;
   logic                  dev_match;
   logic                  prot_hit;

   assign byte_done = bit_evt && (cnt_ff == BIT_LAST);
   assign ack_rise  = bit_evt && (cnt_ff == BIT_ACK);
   // Straps in order of transmission: first select bit on the wire is strap 0
   assign dev_match = (link_byte[7:4] == DEV_TYPE)                      // R8
                    && (link_byte[3:1] == {sel_s[0], sel_s[1], sel_s[2]}) // R8
                    && !busy_ff;                                         // R22
   assign prot_hit  = wp_s && (addr_ff[ADDR_W-1 -: 2] == PROT_QUAD);     // R19

   // Next-state logic of the whole engine
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_addr  = addr_ff;
      nxt_tx    = tx_ff;
      nxt_oe    = oe_ff;
      nxt_ack   = ack_ff;
      nxt_busy  = busy_ff;
      nxt_wc    = wc_ff;
      nxt_pbuf  = pbuf_ff;
      nxt_pval  = pval_ff;
      mem_we    = 1'b0;
      // Self-timed write cycle countdown
      if (busy_ff) begin
         if (wc_ff == '0) begin
            nxt_busy = 1'b0;
         end else begin
            nxt_wc = wc_ff - 1'b1;
         end
      end
      if (stop_det) begin
         nxt_state = ST_IDLE;                                            // R3
         nxt_oe    = 1'b0;
         nxt_ack   = 1'b0;
         nxt_cnt   = '0;
         if (state_ff == ST_WDAT && |pval_ff && !busy_ff && !prot_hit) begin
            mem_we   = 1'b1;                                             // R14
            nxt_busy = 1'b1;                                             // R15
            nxt_wc   = WC_CNT_W'(WC_CYC - 1);
            nxt_pval = '0;
         end
      end else if (start_det) begin
         nxt_state = ST_DEV;                                             // R2
         nxt_oe    = 1'b0;
         nxt_ack   = 1'b0;
         nxt_cnt   = '0;
         nxt_pval  = '0;
      end else if (state_ff == ST_IDLE || state_ff == ST_WAIT) begin
         nxt_oe = 1'b0;                                                  // R2
      end else begin
         // Line changes only after the clock has fallen
         if (scl_fall) begin
            if (cnt_ff == BIT_ACK) begin
               nxt_oe = ack_ff;                                          // R4
            end else if (state_ff == ST_RDAT) begin
               nxt_oe = ~tx_ff[3'(BIT_LAST - cnt_ff)];                   // R6
            end else begin
               nxt_oe = 1'b0;
            end
         end
         if (bit_evt) begin
            nxt_cnt = (cnt_ff == BIT_ACK) ? '0 : cnt_ff + 1'b1;
         end
         if (byte_done) begin
            nxt_ack = (state_ff != ST_RDAT);                             // R5
            case (state_ff)
               ST_DEV: begin
                  if (!dev_match) begin
                     nxt_ack   = 1'b0;                                   // R10
                     nxt_state = ST_WAIT;
                  end else if (link_byte[0]) begin
                     nxt_state = ST_RDAT;                                // R9
                  end else begin
                     nxt_state = ST_AHI;                                 // R9
                  end
               end
               ST_AHI: begin
                  nxt_addr[ADDR_W-1:BYTE_W] = link_byte[HI_BITS-1:0];    // R24
                  nxt_state = ST_ALO;                                    // R13
               end
               ST_ALO: begin
                  nxt_addr[BYTE_W-1:0] = link_byte;                      // R12
                  nxt_state = ST_WDAT;                                   // R13
               end
               ST_WDAT: begin
                  nxt_pbuf[addr_ff[OFS_W-1:0]] = link_byte;              // R16
                  nxt_pval[addr_ff[OFS_W-1:0]] = 1'b1;
                  nxt_addr = page_step(addr_ff);                         // R17 R23
               end
               default: begin
                  nxt_ack = 1'b0;
               end
            endcase
         end
         if (ack_rise) begin
            nxt_ack = 1'b0;
            // Ninth-rise bit: own address ack or master ack fetches a byte
            if (state_ff == ST_RDAT) begin
               if (!link_byte[0]) begin
                  nxt_tx   = mem[addr_ff];                               // R6
                  nxt_addr = addr_ff + 1'b1;
               end else begin
                  nxt_state = ST_WAIT;                                   // R6
               end
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= '0;
         addr_ff  <= '0;
         tx_ff    <= '0;
         oe_ff    <= 1'b0;
         ack_ff   <= 1'b0;
         busy_ff  <= 1'b0;
         wc_ff    <= '0;
         pval_ff  <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         addr_ff  <= nxt_addr;
         tx_ff    <= nxt_tx;
         oe_ff    <= nxt_oe;
         ack_ff   <= nxt_ack;
         busy_ff  <= nxt_busy;
         wc_ff    <= nxt_wc;
         pval_ff  <= nxt_pval;
      end
   end

   // Page buffer contents need no reset; the valid mask guards them
   always_ff @(posedge ref_clk) begin
      pbuf_ff <= nxt_pbuf;
   end

   // ==========================================================================
   // Array: whole page committed at once, only loaded bytes change
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
         if (mem_we && pval_ff[i]) begin
            mem[{addr_ff[ADDR_W-1:OFS_W], OFS_W'(i)}] <= pbuf_ff[i];     // R11
         end
      end
   end

   // Open drain: only ever pulls low
   assign sda_out    = 1'b0;
   assign sda_oe     = oe_ff;
   assign write_busy = busy_ff;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_oe_clock_low: assert property ($changed(oe_ff) |-> !scl_s)             // R1
      else $error("data line driver changed while clock high");
   a_idle_no_drive: assert property (state_ff == ST_IDLE |-> !oe_ff)        // R2
      else $error("data line driven while idle");
   a_stop_to_idle: assert property (stop_det |=> state_ff == ST_IDLE && !oe_ff) // R3
      else $error("stop did not return to standby");
   a_ack_slot_drive: assert property (scl_fall && cnt_ff == BIT_ACK && ack_ff
      && !start_det && !stop_det |=> oe_ff)                                 // R4
      else $error("acknowledge not driven in ninth clock");
   a_mismatch_nack: assert property (state_ff == ST_DEV && byte_done && !dev_match
      && !stop_det && !start_det |=> state_ff == ST_WAIT && !ack_ff)        // R10
      else $error("mismatched address acknowledged");
   a_dir_read: assert property (state_ff == ST_DEV && byte_done && dev_match
      && link_byte[0] && !stop_det && !start_det |=> state_ff == ST_RDAT)   // R9
      else $error("read direction not selected");
   a_write_start: assert property (stop_det && state_ff == ST_WDAT && |pval_ff
      && !busy_ff && !prot_hit |=> busy_ff ##1 busy_ff)                     // R14
      else $error("stop after data did not start write cycle");
   a_busy_quiet: assert property (busy_ff |-> !oe_ff)                       // R15
      else $error("line driven during write cycle");
   a_busy_length: assert property ($rose(busy_ff) |-> wc_ff == WC_CNT_W'(WC_CYC - 1)) // R15
      else $error("write cycle length wrong");
   a_page_hold: assert property (state_ff == ST_WDAT && byte_done && !stop_det
      && !start_det |=> addr_ff[ADDR_W-1:OFS_W] == $past(addr_ff[ADDR_W-1:OFS_W])
      && addr_ff[OFS_W-1:0] == $past(addr_ff[OFS_W-1:0]) + 5'h01)           // R17
      else $error("page number moved during load");
   a_protect_block: assert property (mem_we |-> !prot_hit)                  // R19
      else $error("write into protected quadrant");
   a_busy_no_ack: assert property (busy_ff && state_ff == ST_DEV && byte_done
      |=> !ack_ff)                                                          // R22
      else $error("address acknowledged while busy");

   c_write_commit: cover property (mem_we);
   c_read_byte: cover property (state_ff == ST_RDAT && ack_rise && !link_byte[0]);
   c_page_wrap: cover property (state_ff == ST_WDAT && byte_done && &addr_ff[OFS_W-1:0]);
   c_busy_poll: cover property (busy_ff && state_ff == ST_DEV && byte_done);
endmodule : tws_eeprom_slave
`default_nettype wire

// ===== verification/tws_master_model.sv
// Two-wire bus master model that drives the serial clock of the link
`default_nettype none
module tws_master_model (
   input  wire logic link_clk,
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================================
   // Bus phases
   localparam int HALF = 9; // Link cycles per phase, keeps every phase above 100 ns
   // Clock stands high and line is released while no frame runs
   initial begin
      scl    = 1'b1;
      sda_oe = 1'b0;
   end
   // One phase of the serial clock
   task automatic half();
      repeat (HALF) @(posedge link_clk);
      #1;
   endtask : half
   // Start or repeated start: data falls while the clock is high
   task automatic start();
      sda_oe = 1'b0;
      half();
      scl = 1'b1;
      half();
      sda_oe = 1'b1;
      half();
      scl = 1'b0;
      half();
   endtask : start
   // Stop is only issued from clock low, after the device let go of the line
   task automatic stop();
      sda_oe = 1'b1;
      half();
      scl = 1'b1;
      half();
      sda_oe = 1'b0;
      half();
   endtask : stop
   // Data changes a full phase away from either clock edge
   task automatic xbit(input logic b, output logic r);
      sda_oe = ~b;
      half();
      scl = 1'b1;
      half();
      r = sda_wire;
      scl = 1'b0;
      half();
   endtask : xbit
   // Eight bits most significant first, then the acknowledge clock
   task automatic xbyte(input logic [7:0] d, input logic mack, output logic [7:0] q,
                        output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xbit(d[i], r);
         q[i] = r;
      end
      xbit(mack, r);
      ack = ~r;
   endtask : xbyte
endmodule : tws_master_model
`default_nettype wire

// ===== verification/tws_eeprom_slave_tb_top.sv
// Self-checking bench of the two-wire serial memory slave
`default_nettype none
module tws_eeprom_slave_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import tws_pkg::*;
   // ==========================================================================
   // Clocks, wire and instances
   localparam int WC = 600; // Long enough that a poll lands inside the write cycle
   logic       ref_clk  = 1'b0;
   logic       link_clk = 1'b0;
   logic       rst      = 1'b1;
   logic       wp       = 1'b0;
   logic [2:0] straps   = 3'h0;
   logic       scl, m_oe, d_oe, d_out, busy, sda_w, ack;
   logic [7:0] q;
   logic [7:0] ref_mem [int];
   int         n_fail = 0;
   int         checks = 0;
   int         cyc    = 0;
   // Open-drain wire with pull-up
   assign sda_w = ~m_oe & ~(d_oe & ~d_out);
   always #4 ref_clk = ~ref_clk;
   // Link clock offset so its edges never line up with the system clock
   initial begin
      #2.5;
      forever #6 link_clk = ~link_clk;
   end
   tws_eeprom_slave #(.WC_CYC(WC)) uut (.ref_clk(ref_clk), .rst(rst), .scl(scl),
      .sda_in(sda_w), .sda_out(d_out), .sda_oe(d_oe), .chip_select_straps(straps),
      .write_protect(wp), .write_busy(busy));
   tws_master_model mst (.link_clk(link_clk), .sda_wire(sda_w), .scl(scl), .sda_oe(m_oe));
   // ==========================================================================
   // Checking and closing
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   // Cycle ceiling well above the expected run of about 45000 cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   // ==========================================================================
   // Transfer helpers and reference model
   function automatic logic [7:0] sa(input logic rw);
      return {DEV_TYPE_DEF, straps[0], straps[1], straps[2], rw};
   endfunction : sa
   task automatic sel(input logic [7:0] sb, output logic a);
      mst.start();
      mst.xbyte(sb, 1'b1, q, a);
   endtask : sel
   task automatic wait_idle();
      int t = 0;
      while (busy !== 1'b0 && t < 2 * WC) begin
         @(posedge ref_clk);
         #1;
         t++;
      end
      check("busy end", busy, 1'b0);
   endtask : wait_idle
   task automatic point(input logic [7:0] hi, input logic [7:0] lo);
      sel(sa(1'b0), ack);
      check("slave ack", ack, 1'b1);
      mst.xbyte(hi, 1'b1, q, ack);
      check("hi ack", ack, 1'b1);
      mst.xbyte(lo, 1'b1, q, ack);
      check("lo ack", ack, 1'b1);
   endtask : point
   // Load n random bytes, then expect the write cycle and answer polling, or no write cycle when the address is protected
   task automatic write_run(input logic [7:0] hi, input logic [7:0] lo, input int n);
      logic [12:0] a;
      logic [7:0]  d;
      logic [7:0]  pend [int];
      logic        ok;
      a  = {hi[4:0], lo};
      ok = !(wp && a[12:11] == 2'h3);
      point(hi, lo);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         pend[int'({a[12:5], 5'(a[4:0] + 5'(i))})] = d;
         mst.xbyte(d, 1'b1, q, ack);
         check("data ack", ack, 1'b1);
      end
      mst.stop();
      check("busy", busy, ok);
      if (ok) begin
         foreach (pend[k]) ref_mem[k] = pend[k];
         sel(sa(1'b0), ack);
         check("poll busy", ack, 1'b0);
         mst.stop();
         wait_idle();
         sel(sa(1'b0), ack);
         check("poll done", ack, 1'b1);
         mst.stop();
      end
   endtask : write_run
   // Random read: set address, repeated start, n bytes, last one refused
   task automatic read_run(input logic [12:0] a, input int n);
      point({3'h0, a[12:8]}, a[7:0]);
      sel(sa(1'b1), ack);
      check("read ack", ack, 1'b1);
      for (int i = 0; i < n; i++) begin
         mst.xbyte(8'hFF, i == n - 1, q, ack);
         check("read data", q, ref_mem[int'(a + 13'(i))]);
      end
      mst.stop();
      check("released", d_oe, 1'b0);
      check("drive level", d_out, 1'b0);
   endtask : read_run
   // ==========================================================================
   // Main sequence
   initial begin
      void'($urandom(32'hA01E6798));
      straps = 3'($urandom);
      repeat (3) @(posedge ref_clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge ref_clk);
      // Wrong select and wrong type are refused, the device then waits for a start
      sel(sa(1'b0) ^ 8'h08, ack);
      check("wrong select", ack, 1'b0);
      mst.xbyte(sa(1'b0), 1'b1, q, ack);
      check("no start", ack, 1'b0);
      mst.stop();
      sel(sa(1'b0) ^ 8'h10, ack);
      check("wrong type", ack, 1'b0);
      mst.stop();
      write_run(8'h03, 8'h47, 1);
      read_run(13'h0347, 1);
      // Page load from page start with one extra byte, junk in upper address bits
      write_run(8'hFF, 8'hE0, 33);
      read_run(13'h1FE0, 32);
      @(posedge ref_clk);
      #1 wp = 1'b1;
      repeat (4) @(posedge ref_clk);
      write_run(8'h1F, 8'hE5, 1);
      write_run(8'h00, 8'h05, 2);
      read_run(13'h1FE0, 8);
      read_run(13'h0005, 2);
      tally_and_finish();
   end
endmodule : tws_eeprom_slave_tb_top
`default_nettype wire
